// >>> spi_regs_pkg.sv
// Shared register map, field positions and reset values of the serial core.
package spi_regs_pkg;
    localparam int          DATA_W          = 16;
    localparam int          ADDR_W          = 3;
    localparam logic [2:0]  RX_DATA_ADDR    = 3'h0;
    localparam logic [2:0]  TX_HOLDING_ADDR = 3'h1;
    localparam logic [2:0]  STATUS_ADDR     = 3'h2;
    localparam logic [2:0]  CONTROL_ADDR    = 3'h3;
    localparam logic [2:0]  TARGET_MASK_ADDR = 3'h5;
    localparam int          ROE_BIT         = 3;
    localparam int          TOE_BIT         = 4;
    localparam int          IDLE_BIT        = 5;
    localparam int          TRDY_BIT        = 6;
    localparam int          RRDY_BIT        = 7;
    localparam int          ERR_BIT         = 8;
    localparam int          FORCE_SEL_BIT   = 10;
    localparam logic [15:0] CONTROL_MASK    = 16'h05D8;
    localparam logic [15:0] CONTROL_RESET   = 16'h0000;
    localparam logic [15:0] MASK_RESET      = 16'h0001;
    localparam int          FIFO_DEPTH      = 4;
    localparam int          SCLK_HALF       = 4;
endpackage : spi_regs_pkg

// >>> spi_word_fifo.sv
// Small valid/ready FIFO that carries transmit words to the shifter.
`timescale 1ns/1ps
`default_nettype none
module spi_word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    rd_ptr;
    logic [PW-1:0]    wr_ptr;
    logic [PW:0]      count;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (count < (PW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule : spi_word_fifo
`default_nettype wire

// >>> spi_shifter.sv
// Serial shift engine: one word out on the data line, one word in.
`timescale 1ns/1ps
`default_nettype none
module spi_shifter #(
    parameter int WIDTH = 16,
    parameter int HALF  = 4
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             start,
    input  wire logic [WIDTH-1:0] tx_word,
    input  wire logic             miso_sync,
    output logic                  busy,
    output logic                  done,
    output logic      [WIDTH-1:0] rx_word,
    output logic                  sclk,
    output logic                  mosi
);
    import spi_regs_pkg::*;
    logic [WIDTH-1:0] shreg;
    logic             sample;
    logic [7:0]       div;
    logic [7:0]       bits;
    wire              tick = (div == 8'(HALF - 1));

    assign mosi    = shreg[WIDTH-1];
    assign rx_word = shreg;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            shreg <= '0;
            sample <= 1'b0;
            div   <= 8'h00;
            bits  <= 8'h00;
            busy  <= 1'b0;
            done  <= 1'b0;
            sclk  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!busy) begin
                if (start) begin
                    shreg <= tx_word;
                    busy  <= 1'b1;
                    div   <= 8'h00;
                    bits  <= 8'h00;
                end
            end else begin
                div <= tick ? 8'h00 : div + 8'h01;
                if (tick) begin
                    sclk <= ~sclk;
                    if (!sclk) begin
                        // Capture on the rise and shift on the fall, so the
                        // data line never moves under a rising clock.
                        sample <= miso_sync;
                    end else begin
                        shreg <= {shreg[WIDTH-2:0], sample};
                        if (bits == 8'(WIDTH - 1)) begin
                            busy <= 1'b0;
                            done <= 1'b1;
                        end else begin
                            bits <= bits + 8'h01;
                        end
                    end
                end
            end
        end
    end
endmodule : spi_shifter
`default_nettype wire

// >>> spi_master_regs.sv
// Register file, flags and select logic of the serial master core.
//
// Notes on behaviour
// - Writing the transmit holding register clears transmit-ready.
// - Transmit-ready returns to 1 once the held word moves into the FIFO, one cycle before the shifter loads it.
// - Writing while not ready sets transmit-overrun and drops the word.
// - A held word waits while the shifter is busy; ready stays 0.
// - Status reads return flags with no side effect.
// - A status write clears both overrun flags and the error flag unless a receive overrun sets in that cycle.
// - Bit 3 sets when a word arrives while receive-ready is 1 and receive data is not read in that cycle.
// - Bit 4 sets on a write into a full holding register.
// - Bit 5 is 0 while shifting and 1 only when holding register, FIFO and shifter are all empty.
// - Bit 6 reads 1 whenever the holding register is empty.
// - Bit 7 reads 1 while the receive register holds an unread word.
// - Bit 8 is the OR of the two overrun flags.
// - Control reads return contents with no side effect.
// - Interrupt asserts when any flag and its enable are both 1.
// - Control bits 3, 4 and 8 enable the error interrupts.
// - Control bits 6 and 7 enable the ready interrupts.
// - Control bit 10 holds the masked selects asserted continuously.
// - Reset clears the whole control register.
// - During a shift, exactly the masked active-low selects assert.
// - Reset loads the select mask with only bit 0 set.
// - Reading receive data clears receive-ready unless a word arrives in that cycle; writes there do nothing.
// - Every received word replaces the receive register contents.
`timescale 1ns/1ps
`default_nettype none
module spi_master_regs #(
    parameter int NUM_SEL = 8
) (
    input  wire logic                        ref_clk,
    input  wire logic                        rst_n,
    input  wire logic [spi_regs_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    input  wire logic [spi_regs_pkg::DATA_W-1:0] reg_wdata,
    output logic      [spi_regs_pkg::DATA_W-1:0] reg_rdata,
    output logic                             irq,
    output logic                             sclk,
    output logic                             mosi,
    input  wire logic                        miso,
    output logic      [NUM_SEL-1:0]          ss_n
);
    import spi_regs_pkg::*;

    // Data pin crosses in from the slave side, so two stages first.
    logic              miso_meta;
    logic              miso_sync;

    logic [DATA_W-1:0] rx_data;
    logic [DATA_W-1:0] control_reg;
    logic [DATA_W-1:0] target_mask_reg;
    logic              rx_ready;
    logic              rx_overrun;
    logic              tx_overrun;

    logic              fifo_valid;
    logic              fifo_ready;
    logic [DATA_W-1:0] fifo_data;
    logic              shift_busy;
    logic              shift_done;
    logic [DATA_W-1:0] shift_rx;
    logic              sclk_int;
    logic              mosi_int;

    wire wr_tx      = reg_wr && (reg_addr == TX_HOLDING_ADDR);
    wire wr_status  = reg_wr && (reg_addr == STATUS_ADDR);
    wire wr_control = reg_wr && (reg_addr == CONTROL_ADDR);
    wire wr_mask    = reg_wr && (reg_addr == TARGET_MASK_ADDR);
    wire rd_rx      = reg_rd && (reg_addr == RX_DATA_ADDR);

    // The holding register is a single word; the four-deep FIFO below it
    // never holds more than one word, so the host-facing flag stays exact.
    logic              hold_full;
    logic [DATA_W-1:0] hold_word;

    // A word leaves the holding register only when it can go straight on
    // into an idle shifter, so the same word is never queued twice.
    wire hold_move   = hold_full && fifo_ready && !fifo_valid
                    && !shift_busy;
    wire tx_accept   = wr_tx && !hold_full;
    wire tx_reject   = wr_tx && hold_full;
    wire start_shift = fifo_valid && !shift_busy;
    wire shifter_idle = !shift_busy && !fifo_valid && !hold_full;
    wire tx_ready    = !hold_full;
    wire err_flag    = rx_overrun || tx_overrun;

    wire [DATA_W-1:0] status_word;
    assign status_word = {7'h00, err_flag, rx_ready, tx_ready,
                          shifter_idle, tx_overrun, rx_overrun,
                          3'h0};

    wire [DATA_W-1:0] next_rdata;
    assign next_rdata =
        (reg_addr == RX_DATA_ADDR)     ? rx_data :
        (reg_addr == STATUS_ADDR)      ? status_word :
        (reg_addr == CONTROL_ADDR)     ? control_reg :
        (reg_addr == TARGET_MASK_ADDR) ? target_mask_reg :
                                         16'h0000;

    // Each flag but shifter-idle feeds the interrupt through its own enable bit; both overruns also reach it through bit 8 via the error flag.
    wire irq_terms = (rx_overrun && control_reg[ROE_BIT])
                  || (tx_overrun && control_reg[TOE_BIT])
                  || (err_flag   && control_reg[ERR_BIT])
                  || (tx_ready   && control_reg[TRDY_BIT])
                  || (rx_ready   && control_reg[RRDY_BIT]);

    wire sel_active = shift_busy || control_reg[FORCE_SEL_BIT];
    wire [NUM_SEL-1:0] next_ss_n;
    assign next_ss_n = sel_active ? ~target_mask_reg[NUM_SEL-1:0]
                                  : {NUM_SEL{1'b1}};

    spi_word_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (hold_move),
        .in_ready  (fifo_ready),
        .in_data   (hold_word),
        .out_valid (fifo_valid),
        .out_ready (!shift_busy),
        .out_data  (fifo_data)
    );

    spi_shifter #(
        .WIDTH (DATA_W),
        .HALF  (SCLK_HALF)
    ) u_shift (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .start     (start_shift),
        .tx_word   (fifo_data),
        .miso_sync (miso_sync),
        .busy      (shift_busy),
        .done      (shift_done),
        .rx_word   (shift_rx),
        .sclk      (sclk_int),
        .mosi      (mosi_int)
    );

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            miso_meta <= 1'b0;
            miso_sync <= 1'b0;
        end else begin
            miso_meta <= miso;
            miso_sync <= miso_meta;
        end
    end

    // Only one word may wait above the shifter, so the FIFO below never
    // absorbs more than the host has been told is accepted.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hold_full <= 1'b0;
            hold_word <= 16'h0000;
        end else if (tx_accept) begin
            hold_full <= 1'b1;
            hold_word <= reg_wdata;
        end else if (hold_move) begin
            hold_full <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rx_data  <= 16'h0000;
            rx_ready <= 1'b0;
        end else begin
            if (shift_done) begin
                rx_data  <= shift_rx;
                rx_ready <= 1'b1;
            end else if (rd_rx) begin
                rx_ready <= 1'b0;
            end
        end
    end

    // Set beats clear: an event in the clearing cycle is kept.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rx_overrun <= 1'b0;
            tx_overrun <= 1'b0;
        end else begin
            if (shift_done && rx_ready && !rd_rx) begin
                rx_overrun <= 1'b1;
            end else if (wr_status) begin
                rx_overrun <= 1'b0;
            end
            if (tx_reject) begin
                tx_overrun <= 1'b1;
            end else if (wr_status) begin
                tx_overrun <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            control_reg     <= CONTROL_RESET;
            target_mask_reg <= MASK_RESET;
        end else begin
            if (wr_control) begin
                control_reg <= reg_wdata & CONTROL_MASK;
            end
            if (wr_mask) begin
                target_mask_reg <= reg_wdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
            irq       <= 1'b0;
            ss_n      <= {NUM_SEL{1'b1}};
            sclk      <= 1'b0;
            mosi      <= 1'b0;
        end else begin
            reg_rdata <= next_rdata;
            irq       <= irq_terms;
            ss_n      <= next_ss_n;
            sclk      <= sclk_int;
            mosi      <= mosi_int;
        end
    end
endmodule : spi_master_regs
`default_nettype wire

// >>> spi_slave_model.sv
// Behavioural serial target that echoes the previous frame back.
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model #(
    parameter logic [15:0] FIRST = 16'h3C5A
) (
    input  wire logic sclk,
    input  wire logic mosi,
    input  wire logic sel_n,
    output logic      miso
);
    logic [15:0] sh_in = FIRST;
    logic [15:0] out_w = FIRST;
    logic [3:0]  cnt   = 4'h0;
    always @(negedge sel_n) begin
        out_w = sh_in;
        cnt   = 4'h0;
    end
    always @(posedge sclk) if (!sel_n) sh_in = {sh_in[14:0], mosi};
    always @(negedge sclk) if (!sel_n) cnt = cnt + 4'h1;
    // The target drives the line even when released, and then shows the inverse
    // of its last bit so that a stale value cannot pass for a good one.
    assign miso = sel_n ? ~out_w[0] : out_w[4'hF - cnt];
endmodule : spi_slave_model
`default_nettype wire

// >>> spi_master_regs_chk.sv
// Port-level checker for the serial master register block.
`timescale 1ns/1ps
`default_nettype none
module spi_master_regs_chk #(
    parameter int NUM_SEL = 8
) (
    input wire logic                              ref_clk,
    input wire logic                              rst_n,
    input wire logic [spi_regs_pkg::ADDR_W-1:0]   reg_addr,
    input wire logic                              reg_wr,
    input wire logic                              reg_rd,
    input wire logic [spi_regs_pkg::DATA_W-1:0]   reg_wdata,
    input wire logic [spi_regs_pkg::DATA_W-1:0]   reg_rdata,
    input wire logic                              irq,
    input wire logic                              sclk,
    input wire logic                              mosi,
    input wire logic                              miso,
    input wire logic [NUM_SEL-1:0]                ss_n
);
    import spi_regs_pkg::*;
    logic [15:0]       ctl_sh;
    logic [15:0]       msk_sh;
    logic [2:0]        quiet;
    wire [NUM_SEL-1:0] sel_on = ~msk_sh[NUM_SEL-1:0];
    wire               wr_ctl = reg_wr && reg_addr == CONTROL_ADDR;
    wire               wr_msk = reg_wr && reg_addr == TARGET_MASK_ADDR;
    // Shadows let the selects be judged without peeking inside.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctl_sh <= CONTROL_RESET;
            msk_sh <= MASK_RESET;
        end else begin
            ctl_sh <= wr_ctl ? (reg_wdata & CONTROL_MASK) : ctl_sh;
            msk_sh <= wr_msk ? reg_wdata : msk_sh;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n || reg_wr) begin
            quiet <= 3'h0;
        end else begin
            quiet <= quiet + {2'h0, quiet != 3'h7};
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_reset_out;
        $rose(rst_n) |-> !irq && &ss_n && reg_rdata == 16'h0000;
    endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("outputs not idle after reset");
    property p_shift_sel;
        $rose(sclk) && !ctl_sh[FORCE_SEL_BIT] |-> ss_n == sel_on;
    endproperty
    a_shift_sel: assert property (p_shift_sel)
        else $error("selects differ from mask while shifting");
    property p_force_sel;
        ctl_sh[FORCE_SEL_BIT] && quiet == 3'h7 |-> ss_n == sel_on;
    endproperty
    a_force_sel: assert property (p_force_sel)
        else $error("forced selects differ from mask");
    property p_irq_off;
        ctl_sh == 16'h0000 && quiet > 3'h2 |-> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt with all enables off");
    property p_busy_rd;
        reg_addr == STATUS_ADDR && $rose(sclk) |=> !reg_rdata[IDLE_BIT];
    endproperty
    a_busy_rd: assert property (p_busy_rd)
        else $error("shifter idle seen while shifting");
    property p_err_or;
        $past(reg_addr) == STATUS_ADDR |-> reg_rdata[ERR_BIT] ==
            (reg_rdata[ROE_BIT] | reg_rdata[TOE_BIT]);
    endproperty
    a_err_or: assert property (p_err_or)
        else $error("error flag is not the overrun OR");
    property p_ctl_rd;
        $past(reg_addr) == CONTROL_ADDR && quiet > 3'h2 |-> reg_rdata == ctl_sh;
    endproperty
    a_ctl_rd: assert property (p_ctl_rd)
        else $error("control read differs from written value");
    property p_trdy_irq;
        ctl_sh[TRDY_BIT] && quiet > 3'h2 && $past(reg_addr) == STATUS_ADDR &&
            reg_rdata[TRDY_BIT] |-> ##[0:2] irq;
    endproperty
    a_trdy_irq: assert property (p_trdy_irq)
        else $error("no interrupt for enabled transmit ready");
    c_shift: cover property ($rose(sclk));
    c_force: cover property (ctl_sh[FORCE_SEL_BIT] && quiet == 3'h7);
    c_irq: cover property ($rose(irq));
endmodule : spi_master_regs_chk
bind spi_master_regs spi_master_regs_chk #(.NUM_SEL(NUM_SEL)) u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .irq(irq), .sclk(sclk), .mosi(mosi),
    .miso(miso), .ss_n(ss_n)
);
`default_nettype wire

// >>> spi_master_regs_tb.sv
// Register-level testbench of the serial master block.
`timescale 1ns/1ps
`default_nettype none
module spi_master_regs_tb;
    import spi_regs_pkg::*;
    localparam logic [15:0] D1 = 16'hA5F0;
    localparam logic [15:0] D2 = 16'h1234;
    localparam logic [15:0] IEN [3] = '{16'h0010, 16'h0100, 16'h0008};
    logic        ref_clk;
    logic        rst_n;
    logic [2:0]  reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_wdata;
    wire  [15:0] reg_rdata;
    wire         irq;
    wire         sclk;
    wire         mosi;
    wire         miso;
    wire  [7:0]  ss_n;
    int          errors = 0;
    int          checked = 0;
    int          cycles = 0;
    spi_master_regs #(.NUM_SEL(8)) u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .irq(irq), .sclk(sclk), .mosi(mosi),
        .miso(miso), .ss_n(ss_n)
    );
    spi_slave_model u_slave (
        .sclk(sclk), .mosi(mosi), .sel_n(ss_n[0]), .miso(miso)
    );
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(logic [2:0] a, logic [15:0] d);
        @(negedge ref_clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge ref_clk);
        reg_wr    = 1'b0;
    endtask : wr
    task automatic rd(logic [2:0] a, logic [15:0] exp);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge ref_clk);
        reg_rd   = 1'b0;
        chk("reg_rdata", exp, reg_rdata);
    endtask : rd
    task automatic idle(int n);
        repeat (n) @(negedge ref_clk);
    endtask : idle
    task automatic stop_test;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // The whole sequence needs about 400 cycles.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            stop_test();
        end
    end
    initial begin
        rst_n     = 1'b0;
        reg_addr  = 3'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 16'h0000;
        idle(2);
        rst_n = 1'b1;
        rd(CONTROL_ADDR, CONTROL_RESET);
        rd(TARGET_MASK_ADDR, MASK_RESET);
        rd(STATUS_ADDR, 16'h0060);
        rd(3'h4, 16'h0000);
        wr(CONTROL_ADDR, 16'hFFFF);
        idle(3);
        chk("irq", 16'h0001, {15'h0, irq});
        rd(STATUS_ADDR, 16'h0060);
        rd(CONTROL_ADDR, 16'h05D8);
        wr(CONTROL_ADDR, 16'h0000);
        idle(2);
        chk("irq", 16'h0000, {15'h0, irq});
        wr(TARGET_MASK_ADDR, 16'h0005);
        wr(CONTROL_ADDR, 16'h0400);
        idle(10);
        chk("ss_n", 16'h00FA, {8'h00, ss_n});
        wr(CONTROL_ADDR, 16'h0000);
        wr(TARGET_MASK_ADDR, 16'h0001);
        idle(2);
        chk("ss_n", 16'h00FF, {8'h00, ss_n});
        wr(TX_HOLDING_ADDR, D1);
        idle(4);
        rd(STATUS_ADDR, 16'h0040);
        wr(TX_HOLDING_ADDR, D2);
        rd(STATUS_ADDR, 16'h0000);
        // A write while the holding register is full must be dropped.
        wr(TX_HOLDING_ADDR, 16'hFFFF);
        rd(STATUS_ADDR, 16'h0110);
        for (int i = 0; i < 3; i++) begin
            wr(CONTROL_ADDR, IEN[i]);
            idle(2);
            chk("irq", {15'h0, IEN[i] != 16'h0008}, {15'h0, irq});
        end
        wr(CONTROL_ADDR, 16'h0000);
        wr(STATUS_ADDR, 16'h5A5A);
        rd(STATUS_ADDR, 16'h0000);
        idle(150);
        rd(STATUS_ADDR, 16'h00C0);
        idle(150);
        rd(STATUS_ADDR, 16'h01E8);
        rd(RX_DATA_ADDR, D1);
        rd(STATUS_ADDR, 16'h0168);
        wr(RX_DATA_ADDR, 16'hFFFF);
        rd(STATUS_ADDR, 16'h0168);
        rd(RX_DATA_ADDR, D1);
        stop_test();
    end
endmodule : spi_master_regs_tb
`default_nettype wire
